// *** lpfm_params.svh ***
// Constants for the lift pressure fault monitor: codes, thresholds, times.
// Assumes a 200 MHz system clock and millivolt/PSI scaled inputs.
`ifndef LPFM_PARAMS_SVH
`define LPFM_PARAMS_SVH
`define LPFM_CLK_KHZ      200000
`define LPFM_RANGE_MS     500
`define LPFM_HEAD_DIS_MS  2000
`define LPFM_ROD_DIS_MS   3000
`define LPFM_BLINK_ON_MS  250
`define LPFM_BLINK_OFF_MS 250
`define LPFM_GAP_MS       1000
`define LPFM_TAIL_MS      2000
`define LPFM_HIGH_MV      16'h128E
`define LPFM_LOW_MV       16'h00FA
`define LPFM_HEAD_DIS_PSI 16'h00FA
`define LPFM_ROD_DIS_PSI  16'h0032
`define LPFM_DTC_LOW_HI   16'h214B
`define LPFM_DTC_LOW_LO   16'h214C
`define LPFM_DTC_UP_HI    16'h214D
`define LPFM_DTC_UP_LO    16'h214E
`define LPFM_DTC_HEAD_DIS 16'h214F
`define LPFM_DTC_ROD_HI   16'h2150
`define LPFM_DTC_ROD_LO   16'h2151
`define LPFM_DTC_ROD_DIS  16'h2154
`endif

// *** lpfm_pkg.sv ***
// Types shared by the lift pressure fault monitor.
// Assumes inputs are already digitised on the system clock.
package lpfm_pkg;
  typedef struct packed {
    logic [15:0] lower_mv;
    logic [15:0] upper_mv;
    logic [15:0] rod_mv;
    logic [15:0] lower_psi;
    logic [15:0] upper_psi;
    logic [15:0] rod_psi;
  } lpfm_sense_t;

  typedef struct packed {
    logic lift_up;
    logic drive;
    logic lift;
    logic steer;
  } lpfm_motion_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ON   = 5'b00010,
    ST_OFF  = 5'b00100,
    ST_GAP  = 5'b01000,
    ST_TAIL = 5'b10000
  } lpfm_state_t;
endpackage

// *** lpfm_monitor.sv ***
// Lift cylinder pressure fault detection and fault lamp blink-code driver.
// Assumes sensor values and motion flags come from logic on CLK.
`include "lpfm_params.svh"
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Upper head voltage above 4.75V for 500ms raises the upper head high fault.
// - Upper head voltage below 0.25V for 500ms raises the upper head low fault.
// - During lift up, head pressures differing over 250 PSI for 2000ms raise a fault.
// - Rod voltage above 4.75V for 500ms raises the rod high fault.
// - Rod voltage below 0.25V for 500ms raises the rod low fault.
// - Rod pressure not under 50 PSI after 3000ms raises the rod disagreement fault.
// - Rod disagreement detection is held off while driving, lifting or steering.
// - The lamp blinks the first code digit, then the second digit.
// - A pause separates the groups, another follows, and the pattern repeats.
// - The full code goes only to the analyzer port; the lamp shows two digits.
// - Lower head voltage above 4.75V for 500ms raises the lower head high fault.
// - Lower head voltage below 0.25V for 500ms raises the lower head low fault.
module lpfm_monitor
  import lpfm_pkg::*;
#(
  parameter int NUM_FAULTS = 8,
  parameter int TICK_RANGE = `LPFM_RANGE_MS * `LPFM_CLK_KHZ,
  parameter int TICK_HEAD  = `LPFM_HEAD_DIS_MS * `LPFM_CLK_KHZ,
  parameter int TICK_ROD   = `LPFM_ROD_DIS_MS * `LPFM_CLK_KHZ,
  parameter int TICK_ON    = `LPFM_BLINK_ON_MS * `LPFM_CLK_KHZ,
  parameter int TICK_OFF   = `LPFM_BLINK_OFF_MS * `LPFM_CLK_KHZ,
  parameter int TICK_GAP   = `LPFM_GAP_MS * `LPFM_CLK_KHZ,
  parameter int TICK_TAIL  = `LPFM_TAIL_MS * `LPFM_CLK_KHZ
) (
  input  wire logic                  CLK,
  input  wire logic                  RESET_N,
  input  wire lpfm_sense_t           SENSE,
  input  wire lpfm_motion_t          MOTION,
  output var  logic [NUM_FAULTS-1:0] FAULT_FLAGS,
  output var  logic                  FAULT_VALID,
  output var  logic [15:0]           FAULT_CODE,
  output var  logic                  LAMP
);

  localparam logic [15:0] CODES [8] = '{`LPFM_DTC_LOW_HI, `LPFM_DTC_LOW_LO,
    `LPFM_DTC_UP_HI, `LPFM_DTC_UP_LO, `LPFM_DTC_HEAD_DIS, `LPFM_DTC_ROD_HI,
    `LPFM_DTC_ROD_LO, `LPFM_DTC_ROD_DIS};
  localparam int LIMITS [8] = '{TICK_RANGE, TICK_RANGE, TICK_RANGE, TICK_RANGE,
    TICK_HEAD, TICK_RANGE, TICK_RANGE, TICK_ROD};

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic [3:0] code_digit(input logic [15:0] code, input logic sel);
    logic [15:0] d;
    d = sel ? ((code / 16'h0064) % 16'h000A) : (code / 16'h03E8);
    code_digit = d[3:0];
  endfunction

  // Fault conditions
  logic [NUM_FAULTS-1:0] cond;
  logic                  in_motion;

  always_comb begin
    in_motion = MOTION.drive | MOTION.lift | MOTION.steer;
    cond[0] = SENSE.lower_mv > `LPFM_HIGH_MV;
    cond[1] = SENSE.lower_mv < `LPFM_LOW_MV;
    cond[2] = SENSE.upper_mv > `LPFM_HIGH_MV;
    cond[3] = SENSE.upper_mv < `LPFM_LOW_MV;
    cond[4] = MOTION.lift_up &&
              (abs_diff(SENSE.lower_psi, SENSE.upper_psi) > `LPFM_HEAD_DIS_PSI);
    cond[5] = SENSE.rod_mv > `LPFM_HIGH_MV;
    cond[6] = SENSE.rod_mv < `LPFM_LOW_MV;
    cond[7] = !in_motion && (SENSE.rod_psi >= `LPFM_ROD_DIS_PSI);
  end

  // Persistence timers and fault flags
  logic [31:0]           tmr_ff [NUM_FAULTS];
  logic [31:0]           nxt_tmr [NUM_FAULTS];
  logic [NUM_FAULTS-1:0] fault_ff;
  logic [NUM_FAULTS-1:0] nxt_fault;

  always_comb begin
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (!cond[i]) begin
        nxt_tmr[i] = 32'h0000_0000;
      end else if (tmr_ff[i] < 32'(LIMITS[i])) begin
        nxt_tmr[i] = tmr_ff[i] + 32'h0000_0001;
      end else begin
        nxt_tmr[i] = tmr_ff[i];
      end
      nxt_fault[i] = cond[i] && (nxt_tmr[i] == 32'(LIMITS[i]));
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_FAULTS; i++) begin
        tmr_ff[i] <= 32'h0000_0000;
      end
      fault_ff <= '0;
    end else begin
      tmr_ff   <= nxt_tmr;
      fault_ff <= nxt_fault;
    end
  end

  // Code report, lowest index wins
  logic [15:0] sel_code;
  logic [15:0] code_ff;
  logic        valid_ff;
  logic        nxt_valid;

  always_comb begin
    nxt_valid = |nxt_fault;
    sel_code = 16'h0000;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (nxt_fault[i]) begin
        sel_code = CODES[i];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      code_ff  <= 16'h0000;
      valid_ff <= 1'b0;
    end else begin
      code_ff  <= sel_code;
      valid_ff <= nxt_valid;
    end
  end

  // Blink-code sequencer
  lpfm_state_t state_ff;
  lpfm_state_t nxt_state;
  logic [31:0] btmr_ff;
  logic [31:0] nxt_btmr;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic        grp_ff;
  logic        nxt_grp;
  logic [3:0]  dig_ff [2];
  logic [3:0]  nxt_dig [2];
  logic        lamp_ff;
  logic        nxt_lamp;
  logic        expired;
  logic [3:0]  cnt_inc;

  always_comb begin
    nxt_state  = state_ff;
    nxt_btmr   = btmr_ff + 32'h0000_0001;
    nxt_cnt    = cnt_ff;
    nxt_grp    = grp_ff;
    nxt_dig[0] = dig_ff[0];
    nxt_dig[1] = dig_ff[1];
    cnt_inc    = cnt_ff + 4'h1;
    expired    = 1'b0;
    case (state_ff)
      ST_ON:   expired = btmr_ff >= 32'(TICK_ON - 1);
      ST_OFF:  expired = btmr_ff >= 32'(TICK_OFF - 1);
      ST_GAP:  expired = btmr_ff >= 32'(TICK_GAP - 1);
      ST_TAIL: expired = btmr_ff >= 32'(TICK_TAIL - 1);
      default: expired = 1'b0;
    endcase
    case (state_ff)
      ST_IDLE: begin
        nxt_btmr = 32'h0000_0000;
        if (valid_ff) begin
          nxt_dig[0] = code_digit(code_ff, 1'b0);
          nxt_dig[1] = code_digit(code_ff, 1'b1);
          nxt_cnt    = 4'h0;
          nxt_grp    = 1'b0;
          nxt_state  = ST_ON;
        end
      end
      ST_ON: begin
        if (expired) begin
          nxt_btmr = 32'h0000_0000;
          nxt_cnt  = cnt_inc;
          if (cnt_inc >= dig_ff[grp_ff]) begin
            nxt_state = grp_ff ? ST_TAIL : ST_GAP;
          end else begin
            nxt_state = ST_OFF;
          end
        end
      end
      ST_OFF: begin
        if (expired) begin
          nxt_btmr  = 32'h0000_0000;
          nxt_state = ST_ON;
        end
      end
      ST_GAP: begin
        if (expired) begin
          nxt_btmr  = 32'h0000_0000;
          nxt_cnt   = 4'h0;
          nxt_grp   = 1'b1;
          nxt_state = ST_ON;
        end
      end
      ST_TAIL: begin
        if (expired) begin
          nxt_btmr  = 32'h0000_0000;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_btmr  = 32'h0000_0000;
        nxt_state = ST_IDLE;
      end
    endcase
    if (!valid_ff) begin
      nxt_btmr  = 32'h0000_0000;
      nxt_state = ST_IDLE;
    end
    nxt_lamp = (nxt_state == ST_ON);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff  <= ST_IDLE;
      btmr_ff   <= 32'h0000_0000;
      cnt_ff    <= 4'h0;
      grp_ff    <= 1'b0;
      dig_ff[0] <= 4'h0;
      dig_ff[1] <= 4'h0;
      lamp_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      btmr_ff   <= nxt_btmr;
      cnt_ff    <= nxt_cnt;
      grp_ff    <= nxt_grp;
      dig_ff    <= nxt_dig;
      lamp_ff   <= nxt_lamp;
    end
  end

  assign FAULT_FLAGS = fault_ff;
  assign FAULT_VALID = valid_ff;
  assign FAULT_CODE  = code_ff;
  assign LAMP        = lamp_ff;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_lower_high_raise: assert property (cond[0] && tmr_ff[0] == 32'(TICK_RANGE - 1)
    |=> fault_ff[0]) else $error("lower head high fault not raised");
  a_lower_low_raise: assert property ($rose(fault_ff[1]) |-> $past(cond[1])
    && $past(tmr_ff[1]) == 32'(TICK_RANGE - 1)) else $error("lower head low early");
  a_upper_high_raise: assert property ($rose(fault_ff[2]) |-> $past(tmr_ff[2])
    == 32'(TICK_RANGE - 1)) else $error("upper head high timing wrong");
  a_upper_low_raise: assert property (cond[3] && tmr_ff[3] == 32'(TICK_RANGE - 1)
    |=> fault_ff[3]) else $error("upper head low fault not raised");
  a_head_dis_gate: assert property ($rose(fault_ff[4]) |-> $past(MOTION.lift_up)
    && $past(tmr_ff[4]) == 32'(TICK_HEAD - 1)) else $error("head disagreement wrong");
  a_rod_high_raise: assert property ($rose(fault_ff[5]) |-> $past(SENSE.rod_mv)
    > `LPFM_HIGH_MV) else $error("rod high raised without cause");
  a_rod_low_raise: assert property (cond[6] && tmr_ff[6] == 32'(TICK_RANGE - 1)
    |=> fault_ff[6]) else $error("rod low fault not raised");
  a_rod_dis_time: assert property ($rose(fault_ff[7]) |-> $past(tmr_ff[7])
    == 32'(TICK_ROD - 1)) else $error("rod disagreement timing wrong");
  a_rod_dis_motion: assert property (in_motion |=> !fault_ff[7] && tmr_ff[7] == 32'h0000_0000)
    else $error("rod disagreement active in motion");
  a_timer_restart: assert property (!cond[2] |=> tmr_ff[2] == 32'h0000_0000 && !fault_ff[2])
    else $error("persistence timer not restarted");
  a_group_count: assert property ($rose(state_ff == ST_GAP) |-> cnt_ff == dig_ff[0]
    && !LAMP) else $error("first blink group count wrong");
  a_tail_pause: assert property ($rose(state_ff == ST_TAIL) |-> grp_ff
    && cnt_ff == dig_ff[1] && !LAMP) else $error("second group or pause wrong");
  a_code_report: assert property (fault_ff == '0 |-> !FAULT_VALID
    && FAULT_CODE == 16'h0000) else $error("code reported without fault");

  c_rod_dis_fault: cover property ($rose(fault_ff[7]));
  c_full_pattern: cover property ($rose(state_ff == ST_TAIL) ##[1:64] state_ff == ST_IDLE);
  c_clear_mid: cover property (state_ff == ST_ON ##1 !valid_ff);
  c_head_dis: cover property ($rose(fault_ff[4]));

endmodule
`default_nettype wire

// *** lpfm_sensor_model.sv ***
// Transducer model for the lift pressure fault monitor bench.
// Assumes the bench sets each reading in mV and PSI; outputs follow at once.
`timescale 1ns/10ps
`default_nettype none
module lpfm_sensor_model
  import lpfm_pkg::*;
(
  input  wire logic [15:0] lower_mv,
  input  wire logic [15:0] upper_mv,
  input  wire logic [15:0] rod_mv,
  input  wire logic [15:0] lower_psi,
  input  wire logic [15:0] upper_psi,
  input  wire logic [15:0] rod_psi,
  output var  lpfm_sense_t sense
);
  // Steady transducer levels, no added latency
  always_comb begin
    sense = {lower_mv, upper_mv, rod_mv, lower_psi, upper_psi, rod_psi};
  end
endmodule
`default_nettype wire

// *** tb_lpfm_monitor.sv ***
// Testbench for the lift pressure fault monitor.
// Assumes shortened tick parameters and the transducer model beside it.
`timescale 1ns/10ps
`default_nettype none
module tb_lpfm_monitor
  import lpfm_pkg::*;
;
  localparam int L_RNG  = 20;
  localparam int L_HEAD = 40;
  localparam int L_ROD  = 60;
  localparam int T_ON   = 4;
  localparam int T_OFF  = 4;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  logic [15:0]  mv [3];
  logic [15:0]  psi [3];
  lpfm_motion_t motion = '0;
  lpfm_sense_t  sense;
  logic [7:0]   flags;
  logic         valid;
  logic [15:0]  code;
  logic         lamp;
  int           num_errors = 0;
  int           samples_checked = 0;

  always #2.5 clk = ~clk;

  lpfm_sensor_model u_lpfm_sensor_model (.lower_mv(mv[0]), .upper_mv(mv[1]), .rod_mv(mv[2]),
    .lower_psi(psi[0]), .upper_psi(psi[1]), .rod_psi(psi[2]), .sense(sense));

  lpfm_monitor #(.TICK_RANGE(L_RNG), .TICK_HEAD(L_HEAD), .TICK_ROD(L_ROD), .TICK_ON(T_ON),
    .TICK_OFF(T_OFF), .TICK_GAP(10), .TICK_TAIL(16)) u_lpfm_monitor (.CLK(clk),
    .RESET_N(reset_n), .SENSE(sense), .MOTION(motion), .FAULT_FLAGS(flags),
    .FAULT_VALID(valid), .FAULT_CODE(code), .LAMP(lamp));

  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic outs(input logic [7:0] f, input logic [15:0] c);
    chk("flags", {8'h00, f}, {8'h00, flags});
    chk("valid", {15'h0000, |f}, {15'h0000, valid});
    chk("code", c, code);
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Condition applied at the last edge; nothing at L-1 edges, fault at L
  task automatic trial(input int n, input logic [7:0] f, input logic [15:0] c);
    hold(n - 1);
    outs(8'h00, 16'h0000);
    hold(1);
    outs(f, c);
  endtask

  task automatic nominal();
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      mv[i] <= 16'h09C4;
      psi[i] <= 16'h03E8;
    end
    psi[2] <= 16'h0000;
    motion <= '0;
    hold(2);
    outs(8'h00, 16'h0000);
    chk("lamp", 16'h0000, {15'h0000, lamp});
  endtask

  task automatic range_faults();
    logic [2:0] b;
    for (int k = 0; k < 6; k++) begin
      b = (k < 4) ? 3'(k) : 3'(k + 1);
      @(posedge clk);
      mv[k / 2] <= (k % 2) ? 16'h00F9 : 16'h128F;
      trial(L_RNG, 8'h01 << b, 16'h214B + 16'(b));
      nominal();
    end
  endtask

  task automatic head_disagree();
    @(posedge clk);
    motion.lift_up <= 1'b1;
    psi[1] <= 16'h04E2;
    hold(L_HEAD + 2);
    outs(8'h00, 16'h0000);
    @(posedge clk);
    psi[1] <= 16'h04E3;
    hold(L_HEAD - 2);
    @(posedge clk);
    motion.lift_up <= 1'b0;
    hold(1);
    outs(8'h00, 16'h0000);
    @(posedge clk);
    motion.lift_up <= 1'b1;
    trial(L_HEAD, 8'h10, 16'h214F);
    nominal();
  endtask

  task automatic rod_disagree();
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      psi[2] <= 16'h0032;
      motion <= lpfm_motion_t'(4'h1 << m);
      hold(L_ROD + 2);
      outs(8'h00, 16'h0000);
    end
    @(posedge clk);
    psi[2] <= 16'h0031;
    motion <= '0;
    hold(L_ROD + 2);
    outs(8'h00, 16'h0000);
    @(posedge clk);
    psi[2] <= 16'h0032;
    trial(L_ROD, 8'h80, 16'h2154);
    nominal();
  endtask

  task automatic lamp_code();
    int hi;
    int lo;
    int grp;
    int n;
    int exp_g [3] = '{8, 5, 8};
    @(posedge clk);
    mv[1] <= 16'h128F;
    trial(L_RNG, 8'h04, 16'h214D);
    hi = 0;
    lo = 0;
    grp = 0;
    n = 0;
    for (int t = 0; t < 600 && grp < 3; t++) begin
      hold(1);
      if (lamp === 1'b1) begin
        hi++;
        lo = 0;
      end else begin
        if (hi > 0) begin
          chk("blink length", 16'(T_ON), 16'(hi));
          n++;
        end
        hi = 0;
        lo++;
        if (lo == T_OFF + 1 && n > 0) begin
          chk("blink count", 16'(exp_g[grp]), 16'(n));
          grp++;
          n = 0;
        end
      end
    end
    if (grp < 3) begin
      chk("blink groups", 16'h0003, 16'(grp));
      wrap_up();
    end
    nominal();
  endtask

  initial begin
    for (int i = 0; i < 3; i++) begin
      mv[i] = 16'h09C4;
      psi[i] = 16'h03E8;
    end
    psi[2] = 16'h0000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    hold(1);
    outs(8'h00, 16'h0000);
    range_faults();
    head_disagree();
    rod_disagree();
    lamp_code();
    wrap_up();
  end
endmodule
`default_nettype wire
